// [inc/csw_pkg.sv]
// csw_pkg: register map, field layout, codes and carrier types of the chip select/wait controller
package csw_pkg;

  // ------------------------------------------------------------------
  // register map, byte offsets on the avalon slave
  // ------------------------------------------------------------------
  localparam logic [5:0] OFS_AREA0_CTL = 6'h00;
  localparam logic [5:0] OFS_OUT_CTL = 6'h10;
  localparam logic [5:0] OFS_START0 = 6'h14;
  localparam logic [5:0] OFS_MASK0 = 6'h24;
  localparam logic [5:0] OFS_STATUS = 6'h34;
  localparam logic [5:0] REG_STRIDE = 6'h04;
  localparam int NUM_AREAS = 4;
  localparam int AREA_FULL_RANGE = 2;

  // ------------------------------------------------------------------
  // area control register fields
  // ------------------------------------------------------------------
  localparam int CTL_ENABLE = 7;
  localparam int CTL_AREA_SEL = 6;
  localparam int CTL_WAVE_LSB = 4;
  localparam int WAVE_W = 2;
  localparam int CTL_WIDTH = 3;
  localparam int CTL_WAIT_LSB = 0;
  localparam int WAIT_W = 3;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CTL_RESET_OFF = 8'h00;
  localparam logic [7:0] CTL_RESET_AREA2 = 8'h80;
  localparam logic [7:0] ADDR_REG_RESET = 8'hff;
  localparam logic [2:0] PIN_RESET_LEVEL = 3'h7;

  // ------------------------------------------------------------------
  // codes and counts
  // ------------------------------------------------------------------
  localparam logic [2:0] WAIT_TWO = 3'h0;
  localparam logic [2:0] WAIT_ONE = 3'h1;
  localparam logic [2:0] WAIT_ONE_PLUS = 3'h2;
  localparam logic [2:0] WAIT_NONE = 3'h3;
  localparam logic [2:0] WAIT_SAMPLED = 3'h4;
  localparam logic [1:0] WAVE_ROM_SRAM = 2'h0;
  localparam logic [1:0] WAVE_PSRAM = 2'h1;
  localparam logic [1:0] WAITS_TWO = 2'h2;
  localparam logic [1:0] WAITS_ONE = 2'h1;
  localparam logic [1:0] WAITS_ZERO = 2'h0;
  localparam logic [2:0] BYTES_ONE = 3'h1;
  localparam logic [2:0] BYTES_TWO = 3'h2;
  localparam logic [2:0] BYTES_FOUR = 3'h4;
  localparam logic [23:0] AREA2_FULL_LO = 24'h0008a0;
  localparam logic [23:0] AREA2_FULL_HI_DEFAULT = 24'hfeffff;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {CSW_BYTE, CSW_WORD, CSW_LONG} csw_size_t;

  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } csw_avs_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    csw_size_t size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } csw_req_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dout;
    logic oe_hi;
    logic oe_lo;
    logic rd_n;
    logic wr_hi_n;
    logic wr_lo_n;
    logic [3:0] cs_n;
  } csw_ext_out_t;

endpackage

// [core/csw_pin_sync.sv]
// csw_pin_sync: three-stage pin synchroniser, output moves when stages two and three agree
module csw_pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // pins in, clean levels out
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_pins
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } csw_sync_state_t;

  csw_sync_state_t sync_reg;
  csw_sync_state_t sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = i_pins;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    // a bit only moves once the two late stages agree, so one odd sample is not taken
    for (int k = 0; k < WIDTH; k++) begin
      if (sync_reg.s2[k] == sync_reg.s3[k]) begin
        sync_next.level[k] = sync_reg.s3[k];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_reg <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_pins = sync_reg.level;

endmodule

// [core/csw_ctrl.sv]
// csw_ctrl: chip select, dynamic bus sizing and wait state control for the external bus
// ------------------------------------------------------------------
// Notes on behaviour
// - control bit 7 is the area master enable; one applies settings, zero disables
// - reset clears enables of areas 0, 1, 3 and sets area 2 enable
// - waveform code 00 gives rom/sram select timing on the area select pin
// - waveform code 01 gives pseudo-static ram select timing
// - width bit zero means 16-bit bus, one means 8-bit bus, outside too
// - external-access pin low and width pin high force every area 8 bits wide
// - byte operand, one cycle; odd goes on upper lanes only on 16-bit bus
// - word/long split at consecutive addresses, low byte first, odd start alone
// - read ignores byte lanes carrying no part of the operand
// - write floats unused lanes and keeps their write strobe inactive
// - wait code 000 inserts exactly two waits, wait pin ignored
// - wait code 001 inserts exactly one wait, wait pin ignored
// - wait code 010 inserts one wait then extends while wait pin low
// - wait code 011 ends the cycle with no waits
// - wait code 100 samples wait pin from the start, zero or more waits
// - only codes 000 to 100 defined; reset loads 000 in all wait fields
// - addresses outside all areas use the outside-area width and wait settings
// - mask widths give area sizes 256b-2m, 256b-4m, 32k-8m for areas 0, 1 and 2, 3
// - an area matches where address equals start on every unmasked bit; area 2 with bit 6 clear matches a fixed range
// - when enabled areas overlap the lowest numbered area wins
// ------------------------------------------------------------------
module csw_ctrl #(
  parameter logic [23:0] AREA2_FULL_HI = csw_pkg::AREA2_FULL_HI_DEFAULT
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // avalon-mm register slave
  input wire csw_pkg::csw_avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // operand requests from the cpu side
  input wire csw_pkg::csw_req_t i_cpu_req,
  output logic o_cpu_done,
  output logic [31:0] o_cpu_rdata,
  output logic o_cpu_busy,
  // external bus pins
  input wire logic [15:0] i_ext_data,
  input wire logic i_ext_wait_n,
  input wire logic i_bus_width_select_pin,
  input wire logic i_external_access_pin,
  output csw_pkg::csw_ext_out_t o_ext
);
  import csw_pkg::*;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} csw_fsm_t;

  typedef struct packed {
    logic [NUM_AREAS-1:0] sel;
    logic psram;
    logic hi;
    logic lo;
    logic two;
    logic [1:0] cnt;
    logic sampled;
    logic [15:0] dout;
  } csw_piece_t;

  typedef struct packed {
    csw_fsm_t fsm;
    logic ack;
    logic [31:0] avs_rdata;
    logic [NUM_AREAS:0][7:0] ctl;
    logic [NUM_AREAS-1:0][7:0] start;
    logic [NUM_AREAS-1:0][7:0] mask;
    logic [23:0] addr;
    logic [2:0] remain;
    logic [1:0] idx;
    logic write;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
    csw_piece_t pc;
  } csw_state_t;

  localparam csw_state_t STATE_RESET = '{
    fsm: ST_IDLE,
    ctl: {CTL_RESET_OFF, CTL_RESET_OFF, CTL_RESET_AREA2, CTL_RESET_OFF, CTL_RESET_OFF},
    start: {NUM_AREAS{ADDR_REG_RESET}},
    mask: {NUM_AREAS{ADDR_REG_RESET}},
    default: '0
  };

  csw_state_t state_reg;
  csw_state_t state_next;
  logic [2:0] pins_s;
  logic wait_n_s;
  logic force8;
  logic [31:0] rd_value;
  csw_piece_t first_pc;
  csw_piece_t next_pc;
  logic [2:0] step;
  logic [23:0] addr_step;
  logic [1:0] idx_step;
  logic [2:0] remain_step;
  logic [2:0] req_bytes;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  csw_pin_sync #(
    .WIDTH(3),
    .RESET_LEVEL(PIN_RESET_LEVEL)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_pins({i_ext_wait_n, i_bus_width_select_pin, i_external_access_pin}),
    .o_pins(pins_s)
  );

  assign wait_n_s = pins_s[2];
  assign force8 = !pins_s[0] && pins_s[1];

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] byte_of(logic [31:0] w, logic [1:0] idx);
    return w[idx*8 +: 8];
  endfunction

  // address bits left out of the compare; the narrow mask fields set the area sizes
  function automatic logic [23:0] mask_ignore(int k, logic [7:0] m);
    logic [23:0] ign;
    case (k)
      0: ign = {3'h0, m[7:2], {6{m[1]}}, m[0], 8'hff};
      1: ign = {2'h0, m[7:2], {7{m[1]}}, m[0], 8'hff};
      default: ign = {1'h0, m, 15'h7fff};
    endcase
    return ign;
  endfunction

  function automatic logic area_hit(int k, csw_state_t s, logic [23:0] a);
    logic hit;
    if (k == AREA_FULL_RANGE && !s.ctl[k][CTL_AREA_SEL]) begin
      hit = (a >= AREA2_FULL_LO) && (a <= AREA2_FULL_HI);
    end else begin
      hit = ((a ^ {s.start[k], 16'h0000}) & ~mask_ignore(k, s.mask[k])) == 24'h000000;
    end
    return hit;
  endfunction

  // works out area, lanes, write data and wait profile of one bus cycle
  function automatic csw_piece_t plan_piece(csw_state_t s, logic [23:0] a, logic [1:0] idx,
                                            logic [2:0] remain, logic [31:0] wd, logic f8);
    csw_piece_t p;
    logic [7:0] cfg;
    logic wide;
    int hit;
    p = '0;
    hit = NUM_AREAS;
    for (int k = NUM_AREAS - 1; k >= 0; k--) begin
      if (s.ctl[k][CTL_ENABLE] && area_hit(k, s, a)) begin
        hit = k;
      end
    end
    cfg = s.ctl[hit];
    if (hit < NUM_AREAS) begin
      p.sel[hit] = 1'b1;
      p.psram = cfg[CTL_WAVE_LSB +: WAVE_W] == WAVE_PSRAM;
    end
    wide = !cfg[CTL_WIDTH] && !f8;
    p.two = wide && !a[0] && (remain >= BYTES_TWO);
    p.hi = wide && (a[0] || p.two);
    p.lo = !(wide && a[0]);
    if (p.hi) begin
      p.dout[15:8] = byte_of(wd, p.two ? idx + 2'h1 : idx);
    end
    if (p.lo) begin
      p.dout[7:0] = byte_of(wd, idx);
    end
    case (cfg[CTL_WAIT_LSB +: WAIT_W])
      WAIT_TWO: p.cnt = WAITS_TWO;
      WAIT_ONE: p.cnt = WAITS_ONE;
      WAIT_ONE_PLUS: begin
        p.cnt = WAITS_ONE;
        p.sampled = 1'b1;
      end
      WAIT_NONE: p.cnt = WAITS_ZERO;
      WAIT_SAMPLED: begin
        p.cnt = WAITS_ZERO;
        p.sampled = 1'b1;
      end
      // undefined codes run as the safest setting
      default: p.cnt = WAITS_TWO;
    endcase
    return p;
  endfunction

  // ------------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_value = '0;
    for (int k = 0; k < NUM_AREAS; k++) begin
      if (i_avs.address == OFS_AREA0_CTL + REG_STRIDE * 6'(k)) begin
        rd_value[7:0] = state_reg.ctl[k];
      end
      if (i_avs.address == OFS_START0 + REG_STRIDE * 6'(k)) begin
        rd_value[7:0] = state_reg.start[k];
      end
      if (i_avs.address == OFS_MASK0 + REG_STRIDE * 6'(k)) begin
        rd_value[7:0] = state_reg.mask[k];
      end
    end
    if (i_avs.address == OFS_OUT_CTL) begin
      rd_value[7:0] = state_reg.ctl[NUM_AREAS];
    end
    if (i_avs.address == OFS_STATUS) begin
      rd_value[7:0] = {state_reg.fsm != ST_IDLE, force8, wait_n_s, 1'b0, state_reg.pc.sel};
    end
  end

  // ------------------------------------------------------------------
  // piece planning and stepping
  // ------------------------------------------------------------------
  always_comb begin
    case (i_cpu_req.size)
      CSW_BYTE: req_bytes = BYTES_ONE;
      CSW_WORD: req_bytes = BYTES_TWO;
      default: req_bytes = BYTES_FOUR;
    endcase
    step = state_reg.pc.two ? BYTES_TWO : BYTES_ONE;
    addr_step = state_reg.addr + {21'h000000, step};
    idx_step = state_reg.idx + step[1:0];
    remain_step = state_reg.remain - step;
    first_pc = plan_piece(state_reg, i_cpu_req.addr, 2'h0, req_bytes, i_cpu_req.wdata, force8);
    next_pc = plan_piece(state_reg, addr_step, idx_step, remain_step, state_reg.wdata, force8);
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;

    // register slave: one wait cycle, write lands on the edge that ends the cycle after it
    if ((i_avs.read || i_avs.write) && !state_reg.ack) begin
      state_next.ack = 1'b1;
      state_next.avs_rdata = rd_value;
    end else begin
      state_next.ack = 1'b0;
    end
    if (i_avs.write && state_reg.ack && i_avs.byteenable[0]) begin
      for (int k = 0; k < NUM_AREAS; k++) begin
        if (i_avs.address == OFS_AREA0_CTL + REG_STRIDE * 6'(k)) begin
          state_next.ctl[k] = i_avs.writedata[7:0];
        end
        if (i_avs.address == OFS_START0 + REG_STRIDE * 6'(k)) begin
          state_next.start[k] = i_avs.writedata[7:0];
        end
        if (i_avs.address == OFS_MASK0 + REG_STRIDE * 6'(k)) begin
          state_next.mask[k] = i_avs.writedata[7:0];
        end
      end
      if (i_avs.address == OFS_OUT_CTL) begin
        state_next.ctl[NUM_AREAS] = i_avs.writedata[7:0];
      end
    end

    // bus sequencer; settings written mid-operand apply from the next piece on
    case (state_reg.fsm)
      ST_IDLE: begin
        if (i_cpu_req.valid && !state_reg.done) begin
          state_next.addr = i_cpu_req.addr;
          state_next.remain = req_bytes;
          state_next.idx = 2'h0;
          state_next.write = i_cpu_req.write;
          state_next.wdata = i_cpu_req.wdata;
          state_next.rdata = '0;
          state_next.pc = first_pc;
          state_next.fsm = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_next.fsm = ST_DATA;
      end
      ST_DATA: begin
        if (state_reg.pc.cnt != WAITS_ZERO) begin
          state_next.pc.cnt = state_reg.pc.cnt - WAITS_ONE;
        end else if (state_reg.pc.sampled && !wait_n_s) begin
          state_next.fsm = ST_DATA;
        end else begin
          // only lanes that belong to the operand are taken
          if (!state_reg.write) begin
            if (state_reg.pc.two) begin
              state_next.rdata[state_reg.idx*8 +: 16] = i_ext_data;
            end else if (state_reg.pc.hi) begin
              state_next.rdata[state_reg.idx*8 +: 8] = i_ext_data[15:8];
            end else begin
              state_next.rdata[state_reg.idx*8 +: 8] = i_ext_data[7:0];
            end
          end
          state_next.addr = addr_step;
          state_next.idx = idx_step;
          state_next.remain = remain_step;
          if (remain_step == 3'h0) begin
            state_next.fsm = ST_IDLE;
            state_next.done = 1'b1;
          end else begin
            state_next.pc = next_pc;
            state_next.fsm = ST_ADDR;
          end
        end
      end
      default: begin
        state_next.fsm = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs.read || i_avs.write) && !state_reg.ack;
  assign o_avs_readdata = state_reg.avs_rdata;
  assign o_cpu_done = state_reg.done;
  assign o_cpu_rdata = state_reg.rdata;
  assign o_cpu_busy = state_reg.fsm != ST_IDLE;

  // strobes decode from registered state, so they change only after a clock edge
  always_comb begin
    logic active;
    logic sel_on;
    active = state_reg.fsm == ST_DATA;
    // pseudo-static ram gets its select one state late, giving a precharge gap between pieces
    sel_on = active || (state_reg.fsm == ST_ADDR && !state_reg.pc.psram);
    o_ext.addr = state_reg.addr;
    o_ext.dout = state_reg.pc.dout;
    o_ext.cs_n = ~(sel_on ? state_reg.pc.sel : 4'h0);
    o_ext.rd_n = !(active && !state_reg.write);
    o_ext.wr_hi_n = !(active && state_reg.write && state_reg.pc.hi);
    o_ext.wr_lo_n = !(active && state_reg.write && state_reg.pc.lo);
    o_ext.oe_hi = state_reg.fsm != ST_IDLE && state_reg.write && state_reg.pc.hi;
    o_ext.oe_lo = state_reg.fsm != ST_IDLE && state_reg.write && state_reg.pc.lo;
  end

endmodule

// [tb/csw_mem_model.sv]
// csw_mem_model: external memory and wait source on the far side of the bus
module csw_mem_model (
  // clock
  input wire logic i_clock,
  // bus from the controller
  input wire csw_pkg::csw_ext_out_t i_ext,
  // scenario controls
  input wire logic i_narrow,
  input wire logic i_hold,
  input wire logic [3:0] i_stall,
  // data and wait back
  output logic [15:0] o_data,
  output logic o_wait_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [16];
  logic [3:0] cnt = 4'h0;
  logic [15:0] junk = 16'ha5c3;
  logic [23:0] lo_a;
  logic [7:0] hi_b;
  function automatic logic [7:0] rom(input logic [23:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  assign lo_a = i_narrow ? i_ext.addr : {i_ext.addr[23:1], 1'b0};
  assign hi_b = i_narrow ? junk[15:8] : rom(lo_a | 24'h1);
  // lanes carry a changing pattern while no read strobe is low, and the upper lane does when narrow, so a stale value never passes
  assign o_data = i_ext.rd_n ? junk : {hi_b, rom(lo_a)};
  // wait held low until the strobe has run i_stall cycles, then released
  assign o_wait_n = !(i_hold && cnt < i_stall);
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end
  always @(posedge i_clock) begin
    junk <= ~junk;
    if (i_ext.rd_n && i_ext.wr_lo_n && i_ext.wr_hi_n) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hf) begin
      cnt <= cnt + 4'h1;
    end
    if (!i_ext.wr_lo_n) begin
      mem[lo_a[3:0]] <= i_ext.dout[7:0];
    end
    if (!i_ext.wr_hi_n) begin
      mem[{i_ext.addr[3:1], 1'b1}] <= i_ext.dout[15:8];
    end
  end
endmodule

// [tb/csw_ctrl_chk.sv]
// csw_ctrl_chk: port level assertions of the chip select and wait controller
module csw_ctrl_chk #(
  parameter logic [23:0] AREA2_FULL_HI = csw_pkg::AREA2_FULL_HI_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire csw_pkg::csw_avs_req_t i_avs,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire csw_pkg::csw_req_t i_cpu_req,
  input wire logic o_cpu_done,
  input wire logic [31:0] o_cpu_rdata,
  input wire logic o_cpu_busy,
  input wire logic [15:0] i_ext_data,
  input wire logic i_ext_wait_n,
  input wire logic i_bus_width_select_pin,
  input wire logic i_external_access_pin,
  input wire csw_pkg::csw_ext_out_t o_ext
);
  timeunit 1ns;
  timeprecision 1ns;
  import csw_pkg::*;
  logic cfg_seen;
  logic [2:0] frc_cnt;
  // pins pass a synchroniser, so forcing is judged only after a settled span
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_seen <= 1'b0;
      frc_cnt <= 3'h0;
    end else begin
      if (i_avs.write && !o_avs_waitrequest) begin
        cfg_seen <= 1'b1;
      end
      if (i_external_access_pin || !i_bus_width_select_pin) begin
        frc_cnt <= 3'h0;
      end else if (frc_cnt != 3'h7) begin
        frc_cnt <= frc_cnt + 3'h1;
      end
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  a_lo_lane_oe: assert property (!o_ext.wr_lo_n |-> o_ext.oe_lo)
    else $error("low lane strobe without drive");
  a_hi_lane_oe: assert property (!o_ext.wr_hi_n |-> o_ext.oe_hi)
    else $error("high lane strobe without drive");
  a_one_select: assert property ($onehot0(~o_ext.cs_n))
    else $error("more than one select active");
  a_idle_quiet: assert property (!o_cpu_busy |-> o_ext.cs_n == 4'hf && o_ext.rd_n)
    else $error("select or read strobe while idle");
  a_rd_addr_hold: assert property (!o_ext.rd_n && $past(!o_ext.rd_n) |-> $stable(o_ext.addr))
    else $error("address moved during read strobe");
  a_reset_areas: assert property (!cfg_seen |-> o_ext.cs_n[0] && o_ext.cs_n[1] && o_ext.cs_n[3])
    else $error("disabled area selected after reset");
  a_force_narrow: assert property (frc_cnt == 3'h7 |-> o_ext.wr_hi_n && !o_ext.oe_hi)
    else $error("high lane used while forced narrow");
  a_avs_answer: assert property ($rose(i_avs.read || i_avs.write)
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("register access answer late");
  a_done_pulse: assert property (o_cpu_done |=> !o_cpu_done)
    else $error("done longer than one cycle");
  c_write_done: cover property (o_cpu_done && i_cpu_req.write);
  c_area0_read: cover property (!o_ext.cs_n[0] && !o_ext.rd_n);
  c_forced_write: cover property (frc_cnt == 3'h7 && !o_ext.wr_lo_n);
endmodule
bind csw_ctrl csw_ctrl_chk #(.AREA2_FULL_HI(AREA2_FULL_HI)) i_csw_ctrl_chk (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_avs(i_avs),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_cpu_req(i_cpu_req), .o_cpu_done(o_cpu_done), .o_cpu_rdata(o_cpu_rdata),
  .o_cpu_busy(o_cpu_busy), .i_ext_data(i_ext_data), .i_ext_wait_n(i_ext_wait_n),
  .i_bus_width_select_pin(i_bus_width_select_pin),
  .i_external_access_pin(i_external_access_pin), .o_ext(o_ext)
);

// [tb/tb_top.sv]
// tb_top: register and operand level test of the chip select and wait controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csw_pkg::*;
  logic clock;
  logic arst_n;
  csw_avs_req_t avs;
  logic [31:0] reg_rd;
  logic wreq;
  csw_req_t req;
  logic done;
  logic [31:0] rdata;
  logic busy;
  logic [15:0] ext_data;
  logic wait_n;
  logic wsel;
  logic ext_access;
  csw_ext_out_t ext;
  logic narrow;
  logic hold;
  logic [3:0] cs_seen;
  logic cs_early;
  logic [31:0] q;
  logic [31:0] n;
  logic [31:0] pc [6] = '{4, 3, 3, 2, 2, 4};
  int num_errors = 0;
  int total_checks = 0;

  csw_ctrl i_csw_ctrl (
    .i_clock(clock), .i_arst_n(arst_n), .i_avs(avs), .o_avs_readdata(reg_rd),
    .o_avs_waitrequest(wreq), .i_cpu_req(req), .o_cpu_done(done), .o_cpu_rdata(rdata),
    .o_cpu_busy(busy), .i_ext_data(ext_data), .i_ext_wait_n(wait_n),
    .i_bus_width_select_pin(wsel), .i_external_access_pin(ext_access), .o_ext(ext)
  );
  csw_mem_model i_csw_mem_model (
    .i_clock(clock), .i_ext(ext), .i_narrow(narrow), .i_hold(hold), .i_stall(4'h4),
    .o_data(ext_data), .o_wait_n(wait_n)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge clock) begin
    cs_seen <= cs_seen | ~ext.cs_n;
    cs_early <= cs_early | (ext.cs_n != 4'hf && ext.rd_n && ext.wr_lo_n && ext.wr_hi_n);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_io(input logic w, input logic [5:0] a, input logic [7:0] d);
    avs <= '{a, !w, w, {24'h0, d}, 4'h1};
    // the answer is taken at the rising edge that sees waitrequest low
    do begin
      @(posedge clock);
    end while (wreq);
    q = reg_rd;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    @(posedge clock);
  endtask
  // one operand; n counts cycles from the request to the done pulse
  task automatic op(input logic w, input csw_size_t s, input logic [23:0] a,
                    input logic [31:0] d);
    req <= '{1'b1, w, s, a, d};
    cs_seen = 4'h0;
    cs_early = 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (!done);
    @(posedge clock);
    q = rdata;
    req.valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    avs = '0;
    req = '0;
    wsel = 1'b0;
    ext_access = 1'b1;
    narrow = 1'b0;
    hold = 1'b0;
    arst_n = 1'b0;
    cs_seen = 4'h0;
    cs_early = 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int k = 0; k < 5; k++) begin
      reg_io(1'b0, 6'(k * 4), 8'h00);
      chk("control reset", (k == 2) ? 32'h80 : 32'h0, q);
    end
    reg_io(1'b0, OFS_MASK0, 8'h00);
    chk("mask reset", 32'hff, q);
    reg_io(1'b0, 6'h38, 8'h00);
    chk("unmapped read", 32'h0, q);
    op(1'b0, CSW_BYTE, 24'h001000, 32'h0);
    chk("area2 cycles", 32'h6, n);
    chk("area2 select", 32'h4, {28'h0, cs_seen});
    chk("rom select early", 32'h1, {31'h0, cs_early});
    op(1'b0, CSW_BYTE, 24'h000100, 32'h0);
    chk("outside select", 32'h0, {28'h0, cs_seen});
    // wait codes with the wait pin released and then held
    for (int h = 0; h < 2; h++) begin
      hold <= h[0];
      for (int c = 0; c < 6; c++) begin
        reg_io(1'b1, OFS_OUT_CTL, 8'(c));
        op(1'b0, CSW_BYTE, 24'hff0000, 32'h0);
        chk("outside byte", 32'h5a, {24'h0, q[7:0]});
        if (h == 1 && (c == 2 || c == 4))
          chk("stretched", 32'h1, {31'h0, n > 2 + pc[c]});
        else
          chk("wait cycles", 2 + pc[c], n);
      end
    end
    hold <= 1'b0;
    reg_io(1'b1, OFS_START0, 8'h01);
    reg_io(1'b1, OFS_MASK0, 8'h07);
    reg_io(1'b1, OFS_AREA0_CTL, 8'h83);
    op(1'b1, CSW_LONG, 24'h010001, 32'h44332211);
    chk("odd long cycles", 32'h8, n);
    chk("area0 select", 32'h1, {28'h0, cs_seen});
    for (int k = 0; k < 6; k++)
      chk("written byte", (k == 0 || k == 5) ? 32'h0 : 32'(k * 8'h11),
          {24'h0, i_csw_mem_model.mem[k]});
    op(1'b0, CSW_LONG, 24'h010001, 32'h0);
    chk("odd long read", 32'h5e59585b, q);
    op(1'b0, CSW_BYTE, 24'h010003, 32'h0);
    chk("odd byte read", 32'h59, {24'h0, q[7:0]});
    op(1'b0, CSW_BYTE, 24'h020000, 32'h0);
    chk("unmatched select", 32'h4, {28'h0, cs_seen});
    narrow <= 1'b1;
    reg_io(1'b1, OFS_AREA0_CTL, 8'h8b);
    op(1'b0, CSW_WORD, 24'h010002, 32'h0);
    chk("narrow word", 32'h5958, {16'h0, q[15:0]});
    chk("narrow cycles", 32'h6, n);
    reg_io(1'b1, OFS_AREA0_CTL, 8'h83);
    ext_access <= 1'b0;
    wsel <= 1'b1;
    repeat (8) @(posedge clock);
    op(1'b1, CSW_WORD, 24'h010008, 32'h0000bbaa);
    chk("forced cycles", 32'h6, n);
    chk("forced low", 32'haa, {24'h0, i_csw_mem_model.mem[8]});
    chk("forced high", 32'hbb, {24'h0, i_csw_mem_model.mem[9]});
    ext_access <= 1'b1;
    wsel <= 1'b0;
    narrow <= 1'b0;
    repeat (8) @(posedge clock);
    reg_io(1'b1, OFS_AREA0_CTL, 8'h03);
    reg_io(1'b0, OFS_AREA0_CTL, 8'h00);
    chk("control readback", 32'h03, q);
    op(1'b0, CSW_BYTE, 24'h010000, 32'h0);
    chk("disabled area", 32'h4, {28'h0, cs_seen});
    reg_io(1'b1, 6'h08, 8'h90);
    op(1'b0, CSW_BYTE, 24'h001000, 32'h0);
    chk("psram select early", 32'h0, {31'h0, cs_early});
    chk("psram select", 32'h4, {28'h0, cs_seen});
    // area 2 switched to start and mask: 32 kbyte from 0x300000
    reg_io(1'b1, OFS_START0 + 6'h08, 8'h30);
    reg_io(1'b1, OFS_MASK0 + 6'h08, 8'h00);
    reg_io(1'b1, 6'h08, 8'hc0);
    op(1'b0, CSW_BYTE, 24'h001000, 32'h0);
    chk("range off", 32'h0, {28'h0, cs_seen});
    op(1'b0, CSW_BYTE, 24'h308000, 32'h0);
    chk("range end", 32'h0, {28'h0, cs_seen});
    op(1'b0, CSW_BYTE, 24'h307fff, 32'h0);
    chk("range in", 32'h4, {28'h0, cs_seen});
    results();
  end

  // the tests need a few hundred cycles; a hang is cut well beyond that
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end
endmodule
